// file: design/clock_divider_pll_config.v
// Clock divisor control and loop feedback divisor registers with dividers
//
// Overview of operation
// - Slowdown off forces processor/peripheral ratio 1:1
// - RC postscaler divides by 1..64, or 256
// - RC postscaler field resets to 000
// - Output divider code 00 is /2, 11 is /8
// - Interrupt with recover set clears slowdown enable
// - Feedback divisor bits 15-9 read as zero
// - Slowdown ratio 1..128, resets to divide by 8
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`include "clk_div_map.vh"
module clock_divider_pll_config #(
    parameter AW = 4
) (
    // Clock and reset
    input  wire          mclk,
    input  wire          rst_b,
    // Register port
    input  wire [AW-1:0] reg_addr,
    input  wire [15:0]   reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [15:0]   reg_rdata_r,
    // Interrupt occurrence, asynchronous to mclk
    input  wire          irq_event,
    // Divide factors presented to the clock tree
    output reg  [8:0]    rc_osc_div_r,
    output reg  [7:0]    core_slowdown_div_r,
    output reg  [3:0]    output_divide_factor_r,
    output reg  [5:0]    input_divide_factor_r,
    output reg  [8:0]    loop_feedback_divide_r,
    // Peripheral clock enable derived from slowdown ratio
    output reg           periph_tick_r
);

    // Register fields
    reg        recover_on_interrupt_r;  // Recover on interrupt
    reg [2:0]  core_slowdown_ratio_r;   // Slowdown ratio code
    reg        core_slowdown_enable_r;  // Slowdown enable
    reg [2:0]  rc_osc_postscale_r;      // RC postscaler code
    reg [1:0]  loop_output_divide_r;    // Loop output divider code
    reg [4:0]  loop_input_prescale_r;   // Loop input prescaler code
    reg [8:0]  fbd_r;                   // Feedback divisor field
    // Interrupt synchroniser and edge detect
    reg        irq_meta_r;
    reg        irq_sync_r;
    reg        irq_prev_r;
    wire       irq_pulse = irq_sync_r & ~irq_prev_r;
    wire       tick;

    // Address match helper, used by write and read decode
    function is_addr;
        input [AW-1:0] a;
        input [3:0]    idx;
        begin
            is_addr = (a == idx);
        end
    endfunction

    // RC postscaler code to divide ratio
    function [8:0] rc_div;
        input [2:0] code;
        begin
            if (code == 3'h7) begin
                rc_div = 9'h100;
            end else begin
                rc_div = 9'h001 << code;
            end
        end
    endfunction

    // Two flip-flops before the interrupt level is used
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_meta_r <= 1'b0;
            irq_sync_r <= 1'b0;
            irq_prev_r <= 1'b0;
        end else begin
            irq_meta_r <= irq_event;
            irq_sync_r <= irq_meta_r;
            irq_prev_r <= irq_sync_r;
        end
    end

    // Register writes; hardware clear of slowdown beats a same-cycle set
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            recover_on_interrupt_r <= 1'b0;  // Bit 15 of the reset word
            core_slowdown_ratio_r  <= 3'h3;
            core_slowdown_enable_r <= 1'b0;
            rc_osc_postscale_r     <= 3'h0;
            loop_output_divide_r   <= 2'h0;
            loop_input_prescale_r  <= 5'h00;
            fbd_r                  <= `LFD_RESET;
        end else begin
            if (reg_wr && is_addr(reg_addr, `CDC_ADDR)) begin
                recover_on_interrupt_r <= reg_wdata[`CDC_ROI_BIT];
                core_slowdown_ratio_r  <=
                    reg_wdata[`CDC_RATIO_HI:`CDC_RATIO_LO];
                core_slowdown_enable_r <= reg_wdata[`CDC_SLOW_EN_BIT];
                rc_osc_postscale_r     <=
                    reg_wdata[`CDC_RCPS_HI:`CDC_RCPS_LO];
                // Reserved output code is refused, field keeps old value
                if (reg_wdata[`CDC_OUTDIV_HI:`CDC_OUTDIV_LO]
                        != `OUTDIV_RESERVED) begin
                    loop_output_divide_r <=
                        reg_wdata[`CDC_OUTDIV_HI:`CDC_OUTDIV_LO];
                end
                loop_input_prescale_r  <=
                    reg_wdata[`CDC_INPRE_HI:`CDC_INPRE_LO];
            end
            if (reg_wr && is_addr(reg_addr, `LFD_ADDR)) begin
                fbd_r <= reg_wdata[8:0];
            end
            // Interrupt recovery drops slowdown
            if (irq_pulse && recover_on_interrupt_r) begin
                core_slowdown_enable_r <= 1'b0;
            end
        end
    end

    // Read data stands one cycle after the read strobe
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_r <= 16'h0000;
        end else if (reg_rd && is_addr(reg_addr, `CDC_ADDR)) begin
            reg_rdata_r <= {recover_on_interrupt_r, core_slowdown_ratio_r,
                            core_slowdown_enable_r, rc_osc_postscale_r,
                            loop_output_divide_r, 1'b0,
                            loop_input_prescale_r};
        end else if (reg_rd && is_addr(reg_addr, `LFD_ADDR)) begin
            reg_rdata_r <= {7'h00, fbd_r};
        end else begin
            reg_rdata_r <= 16'h0000;
        end
    end

    // Divide factors for the clock tree
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rc_osc_div_r           <= 9'h001;
            core_slowdown_div_r    <= 8'h01;
            output_divide_factor_r <= 4'h2;
            input_divide_factor_r  <= 6'h02;
            loop_feedback_divide_r <= `LFD_RESET;
        end else begin
            rc_osc_div_r <= rc_div(rc_osc_postscale_r);
            // Ratio only applies while slowdown is enabled
            if (core_slowdown_enable_r) begin
                core_slowdown_div_r <=
                    8'h01 << core_slowdown_ratio_r;
            end else begin
                core_slowdown_div_r <= 8'h01;
            end
            case (loop_output_divide_r)
                2'h0:    output_divide_factor_r <= 4'h2;
                2'h1:    output_divide_factor_r <= 4'h4;
                default: output_divide_factor_r <= 4'h8;
            endcase
            input_divide_factor_r <=
                {1'b0, loop_input_prescale_r} + 6'h02;
            loop_feedback_divide_r <= fbd_r;
        end
    end

    // Peripheral enable pulses at the slowdown ratio
    clk_prescale_cnt #(
        .W (8)
    ) u_slow (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .div_ratio (core_slowdown_div_r),
        .tick_r    (tick)
    );

    // Register the tick so the output comes from a flip-flop
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            periph_tick_r <= 1'b0;
        end else begin
            periph_tick_r <= tick;
        end
    end

endmodule

// file: common/clk_div_map.vh
// Register offsets, field positions, reset values and codes for the clock divider
`ifndef CLK_DIV_MAP_VH
`define CLK_DIV_MAP_VH

// Register indices on the plain register port
`define CDC_ADDR          4'h0
`define LFD_ADDR          4'h1

// Clock divisor control fields
`define CDC_ROI_BIT       15
`define CDC_RATIO_HI      14
`define CDC_RATIO_LO      12
`define CDC_SLOW_EN_BIT   11
`define CDC_RCPS_HI       10
`define CDC_RCPS_LO       8
`define CDC_OUTDIV_HI     7
`define CDC_OUTDIV_LO     6
`define CDC_INPRE_HI      4
`define CDC_INPRE_LO      0

// Reset values
`define CDC_RESET         16'h3000
`define LFD_RESET         9'h030

// Loop output divide codes
`define OUTDIV_RESERVED   2'h2

`endif

// file: design/clk_prescale_cnt.v
// Programmable divide-by-N clock-enable generator
`timescale 1ns/1ns
module clk_prescale_cnt #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         mclk,
    input  wire         rst_b,
    // Divide ratio, one or more
    input  wire [W-1:0] div_ratio,
    // One-cycle tick every div_ratio source cycles
    output reg          tick_r
);

    reg [W-1:0] cnt_r;  // Cycles since last tick

    // Count up to ratio-1 then tick; ratio 1 ticks every cycle
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r  <= {W{1'b0}};
            tick_r <= 1'b0;
        end else if (cnt_r + 1'b1 >= div_ratio) begin
            cnt_r  <= {W{1'b0}};
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

endmodule

// file: dv/cdpc_props.sv
// Assertion checker for the clock divider configuration block
`timescale 1ns/1ns
module cdpc_props #(
    parameter AW = 4
) (
    // Clock, reset and register port
    input wire          mclk,
    input wire          rst_b,
    input wire [AW-1:0] reg_addr,
    input wire [15:0]   reg_wdata,
    input wire          reg_wr,
    input wire          reg_rd,
    input wire [15:0]   reg_rdata_r,
    input wire          irq_event,
    // Divide factors
    input wire [8:0]    rc_osc_div_r,
    input wire [7:0]    core_slowdown_div_r,
    input wire [3:0]    output_divide_factor_r,
    input wire [5:0]    input_divide_factor_r,
    input wire [8:0]    loop_feedback_divide_r,
    input wire          periph_tick_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Control write; factors follow two edges later
    wire ctl_wr = reg_wr && reg_addr == 'h0;

    a_rc_div_set: assert property (rc_osc_div_r inside {9'h001, 9'h002,
        9'h004, 9'h008, 9'h010, 9'h020, 9'h100}) else $error("rc divide bad");
    a_outdiv_set: assert property (
        output_divide_factor_r inside {4'h2, 4'h4, 4'h8})
        else $error("output divide bad");
    a_rc_after_reset: assert property (
        $rose(rst_b) |-> rc_osc_div_r == 9'h001) else $error("rc reset bad");
    a_slow_off_one: assert property (
        ctl_wr && !reg_wdata[11] |-> ##2 core_slowdown_div_r == 8'h01)
        else $error("slowdown off not 1:1");
    a_slow_ratio_wr: assert property (
        ctl_wr && reg_wdata[11] && !reg_wdata[15] |-> ##2
        core_slowdown_div_r == 8'h01 << $past(reg_wdata[14:12], 2))
        else $error("slowdown ratio bad");
    a_rc_div_wr: assert property (
        ctl_wr && reg_wdata[10:8] != 3'h6 |-> ##2 rc_osc_div_r ==
        ($past(reg_wdata[10:8], 2) == 3'h7 ? 9'h100 :
        9'h001 << $past(reg_wdata[10:8], 2))) else $error("rc write bad");
    a_inpre_wr: assert property (
        ctl_wr |-> ##2 input_divide_factor_r == $past(reg_wdata[4:0], 2) + 6'h02)
        else $error("input prescale bad");
    a_fbd_high_zero: assert property (
        reg_rd && reg_addr == 'h1 |=> reg_rdata_r[15:9] == 7'h00)
        else $error("feedback high bits set");
endmodule

bind clock_divider_pll_config cdpc_props #(.AW(AW)) i_props (.*);

// file: dv/tb.sv
// Self-checking testbench for the clock divider configuration block
`timescale 1ns/1ns
module tb;
    reg         mclk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         irq_event = 1'b0;
    wire [15:0] reg_rdata_r;
    wire [8:0]  rc_osc_div_r;
    wire [7:0]  core_slowdown_div_r;
    wire [3:0]  output_divide_factor_r;
    wire [5:0]  input_divide_factor_r;
    wire [8:0]  loop_feedback_divide_r;
    wire        periph_tick_r;
    integer     miscompares = 0;
    integer     n_compared = 0;
    integer     i;
    integer     ticks;          // Peripheral ticks seen in a window
    reg  [42:0] rows [0:7];     // Control word, then rc, slow, out, in

    always #5 mclk = ~mclk;

    clock_divider_pll_config i_dut (.*);

    // Counts a compare; unknown bits must match exactly
    task chk(input [26:0] got, input [26:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Idle edge after the strobe so a next call never double-drives it
    task wr(input [3:0] a, input [15:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge mclk);
            reg_wr <= 1'b0;
            @(posedge mclk);
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input [3:0] a, input [15:0] exp);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata_r, exp);
            @(posedge mclk);
        end
    endtask
    // Interrupt pulse long enough for the input synchroniser
    task irq;
        begin
            irq_event <= 1'b1;
            repeat (4) @(posedge mclk);
            irq_event <= 1'b0;
        end
    endtask
    task tally_and_finish;
        begin
            if (miscompares == 0 && n_compared > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    // Watchdog: the whole sequence needs about a hundred cycles
    initial begin
        repeat (3000) @(posedge mclk);
        miscompares = miscompares + 1;
        tally_and_finish;
    end

    initial begin
        rows[0] = {16'h7000, 9'h001, 8'h01, 4'h2, 6'h02};
        rows[1] = {16'h7F5F, 9'h100, 8'h80, 4'h4, 6'h21};
        rows[2] = {16'h08C1, 9'h001, 8'h01, 4'h8, 6'h03};
        rows[3] = {16'h1D2A, 9'h020, 8'h02, 4'h2, 6'h0C};
        rows[4] = {16'h3B00, 9'h008, 8'h08, 4'h2, 6'h02};
        rows[5] = {16'h4900, 9'h002, 8'h10, 4'h2, 6'h02};
        rows[6] = {16'h5A00, 9'h004, 8'h20, 4'h2, 6'h02};
        rows[7] = {16'h6C00, 9'h010, 8'h40, 4'h2, 6'h02};
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd(4'h0, 16'h3000);
        rd(4'h1, 16'h0030);
        for (i = 0; i < 8; i = i + 1) begin
            wr(4'h0, rows[i][42:27]);
            #1 chk({rc_osc_div_r, core_slowdown_div_r, output_divide_factor_r,
                input_divide_factor_r}, rows[i][26:0]);
            @(posedge mclk);
            rd(4'h0, rows[i][42:27] & 16'hFFDF);
        end
        // Reserved output divide code leaves the field as it was
        wr(4'h0, 16'h00C0);
        wr(4'h0, 16'h0080);
        rd(4'h0, 16'h00C0);
        // Interrupt clears slowdown only with recover set
        wr(4'h0, 16'h0B00);
        irq;
        rd(4'h0, 16'h0B00);
        wr(4'h0, 16'h8B00);
        irq;
        rd(4'h0, 16'h8300);
        // Upper feedback bits and unmapped index
        wr(4'h1, 16'hFFFF);
        wr(4'h2, 16'h1234);
        rd(4'h2, 16'h0000);
        rd(4'h1, 16'h01FF);
        chk(loop_feedback_divide_r, 27'h1FF);
        // Slowdown by two: one peripheral tick every other cycle
        wr(4'h0, 16'h1800);
        repeat (4) @(posedge mclk);
        ticks = 0;
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge mclk);
            #1 ticks = ticks + periph_tick_r;
        end
        chk(ticks, 27'h4);
        // Second reset mid-run
        rst_b <= 1'b0;
        @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd(4'h0, 16'h3000);
        tally_and_finish;
    end
endmodule
